// ### src/csq_crc16.sv
`timescale 1ns/100ps
`default_nettype none
module csq_crc16 (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // serial data
    input wire logic clear_in,
    input wire logic shift_in,
    input wire logic data_in,
    // running remainder
    output logic [15:0] crc_out
);
    logic fb;

    assign fb = data_in ^ crc_out[15];

    // msb-first serial division; clear outranks a shift in the same cycle
    always_ff @(posedge clk_in) begin
        if (!resetn_in || clear_in) begin
            crc_out <= csq_pkg::CRC_INIT;
        end else if (shift_in) begin
            crc_out <= {crc_out[14:0], 1'b0} ^ (fb ? csq_pkg::CRC_POLY : 16'h0000);
        end
    end
endmodule
`default_nettype wire

// ### src/csq_pkg.sv
// Summary of operation
// - shift P to W bits out per host clock
// - Sub Q bit feeds shift register and CRC
// - passing 96-bit block sets flag, loads 80 bits
// - load reverses bit order inside each byte
// - shift clock low holds one-shot in reset
// - held one-shot blocks output register load
// - lock flag readable on Sub Q serial output
`default_nettype none
package csq_pkg;
    // sub q block geometry
    localparam int SUBQ_DATA_BITS = 80;
    localparam int SUBQ_BLOCK_BITS = 96;
    localparam logic [6:0] SUBQ_LAST_DATA = 7'h4F;
    localparam logic [6:0] SUBQ_LAST_BIT = 7'h5F;
    localparam logic [6:0] SUBQ_IDLE_COUNT = 7'h60;
    localparam logic [6:0] SUBQ_LOCK_INDEX = 7'h50;
    // p to w symbol width and index wrap
    localparam int PW_BITS = 8;
    localparam logic [2:0] PW_LAST_INDEX = 3'h7;
    // crc generator, register reset value and check mask
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_ALL_ONES = 16'hFFFF;
    // one-shot time constant and derived cycle count
    localparam int ONESHOT_US = 400;
    localparam int CLK_MHZ = 100;
    localparam logic [15:0] ONESHOT_CYCLES = 16'(ONESHOT_US * CLK_MHZ);

    // one recovered sub q sample from the deinterleaver
    typedef struct packed {
        logic block_start;
        logic valid;
        logic data;
    } csq_subq_sample_t;
endpackage
`default_nettype wire

// ### src/csq_readout.sv
`timescale 1ns/100ps
`default_nettype none
module csq_readout #(
    parameter logic [15:0] ONESHOT_CYCLES = csq_pkg::ONESHOT_CYCLES
) (
    // core clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // recovered subcode from the decoder
    input wire csq_pkg::csq_subq_sample_t subq_sample_in,
    input wire logic [7:0] pw_symbol_in,
    input wire logic write_frame_clock_in,
    input wire logic wide_pll_lock_flag_in,
    // host p to w link
    input wire logic pw_subcode_shift_clock_in,
    output logic pw_subcode_serial_out,
    // host sub q link
    input wire logic subq_shift_clock_in,
    output logic subq_serial_out,
    output logic subcode_block_sync_out,
    output logic subq_crc_ok_flag_out
);
    // sub q collection state
    logic [6:0] bit_cnt;
    logic [79:0] s2p;
    logic [15:0] chk;
    logic [15:0] crc;
    logic block_done;
    logic crc_pass;
    logic [79:0] word;
    logic [79:0] next_word;
    logic crc_flag;
    logic load_now;
    // one-shot and readout state
    logic subq_shift_clock_m;
    logic subq_shift_clock_s;
    logic subq_shift_clock_d;
    logic subq_shift_clock_rise;
    logic subq_shift_clock_fall;
    logic [15:0] os_cnt;
    logic held;
    logic [6:0] rd_idx;
    logic next_out;
    // p to w state
    logic [7:0] pw_hold;
    logic rstl_m;
    logic rstl_s;
    logic [2:0] pw_idx;

    // s2p bit k is stream bit 79-k, so the first bit received sits at the top
    wire data_bit = subq_sample_in.valid && (bit_cnt <= csq_pkg::SUBQ_LAST_DATA);
    wire check_bit = subq_sample_in.valid && (bit_cnt > csq_pkg::SUBQ_LAST_DATA)
        && (bit_cnt <= csq_pkg::SUBQ_LAST_BIT);

    // the crc only sees the 80 data bits; the check field is compared afterwards
    csq_crc16 u_crc (
        .clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .clear_in(subq_sample_in.block_start),
        .shift_in(data_bit),
        .data_in(subq_sample_in.data),
        .crc_out(crc)
    );

    // bit position in the block; parks at idle count until the next block sync
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            bit_cnt <= csq_pkg::SUBQ_IDLE_COUNT;
        end else if (subq_sample_in.block_start) begin
            bit_cnt <= 7'h00;
        end else if (subq_sample_in.valid && bit_cnt < csq_pkg::SUBQ_IDLE_COUNT) begin
            bit_cnt <= bit_cnt + 7'h01;
        end
    end

    // serial-to-parallel data register and check field register
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            s2p <= 80'h0;
            chk <= 16'h0000;
        end else begin
            if (data_bit) begin
                s2p <= {s2p[78:0], subq_sample_in.data};
            end
            if (check_bit) begin
                chk <= {chk[14:0], subq_sample_in.data};
            end
        end
    end

    // block end strobe and block sync echo to the host
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            block_done <= 1'b0;
            subcode_block_sync_out <= 1'b0;
        end else begin
            block_done <= check_bit && (bit_cnt == csq_pkg::SUBQ_LAST_BIT);
            subcode_block_sync_out <= subq_sample_in.block_start;
        end
    end

    // stored check field is the inverted remainder
    assign crc_pass = ((crc ^ chk) == csq_pkg::CRC_ALL_ONES);
    assign load_now = block_done && crc_pass && !held;

    // byte order kept, bit order inside each byte turned round
    genvar gi;
    generate
        for (gi = 0; gi < csq_pkg::SUBQ_DATA_BITS; gi = gi + 1) begin : g_rev
            assign next_word[gi] = s2p[72 - 8 * (gi / 8) + (gi % 8)];
        end
    endgenerate

    // parallel-to-serial word, written only when the one-shot has run out
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            word <= 80'h0;
        end else if (load_now) begin
            word <= next_word;
        end
    end

    // crc flag: set on a passing load, cleared by a failing block seen while not held or by a read start
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            crc_flag <= 1'b0;
        end else if (load_now) begin
            crc_flag <= 1'b1;
        end else if ((block_done && !held) || subq_shift_clock_fall) begin
            crc_flag <= 1'b0;
        end
    end
    assign subq_crc_ok_flag_out = crc_flag;

    // shift clock comes from the host pin, so it is synchronised before use
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            subq_shift_clock_m <= 1'b1;
            subq_shift_clock_s <= 1'b1;
            subq_shift_clock_d <= 1'b1;
        end else begin
            subq_shift_clock_m <= subq_shift_clock_in;
            subq_shift_clock_s <= subq_shift_clock_m;
            subq_shift_clock_d <= subq_shift_clock_s;
        end
    end
    assign subq_shift_clock_rise = subq_shift_clock_s && !subq_shift_clock_d;
    assign subq_shift_clock_fall = !subq_shift_clock_s && subq_shift_clock_d;

    // retriggerable one-shot: zeroed while the clock is low, runs out when high
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            os_cnt <= ONESHOT_CYCLES;
        end else if (!subq_shift_clock_s) begin
            os_cnt <= 16'h0000;
        end else if (os_cnt < ONESHOT_CYCLES) begin
            os_cnt <= os_cnt + 16'h0001;
        end
    end
    assign held = !subq_shift_clock_s || (os_cnt < ONESHOT_CYCLES);

    // read index: bit 0 waits from the first falling edge, rises advance
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in || !held) begin
            rd_idx <= 7'h00;
        end else if (subq_shift_clock_rise && rd_idx < csq_pkg::SUBQ_LOCK_INDEX) begin
            rd_idx <= rd_idx + 7'h01;
        end
    end

    // idle shows the crc flag, then 80 data bits, then the pll lock flag
    always_comb begin
        if (!held) begin
            next_out = crc_flag;
        end else if (rd_idx < csq_pkg::SUBQ_LOCK_INDEX) begin
            next_out = word[rd_idx];
        end else begin
            next_out = wide_pll_lock_flag_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            subq_serial_out <= 1'b0;
        end else begin
            subq_serial_out <= next_out;
        end
    end

    // symbol is captured while the frame clock is high and stays still while
    // it is low, which is exactly when the host shifts it out
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            pw_hold <= 8'h00;
        end else if (write_frame_clock_in) begin
            pw_hold <= pw_symbol_in;
        end
    end

    // reset brought into the host clock domain; the link only leaves reset after
    // two edges of its own, so a host must spend two spare pulses after release
    always_ff @(posedge pw_subcode_shift_clock_in) begin
        rstl_m <= resetn_in;
        rstl_s <= rstl_m;
    end

    // bit index on the host clock; eight pulses per symbol wrap it to p again
    always_ff @(posedge pw_subcode_shift_clock_in) begin
        if (!rstl_s) begin
            pw_idx <= 3'h0;
        end else if (pw_idx == csq_pkg::PW_LAST_INDEX) begin
            pw_idx <= 3'h0;
        end else begin
            pw_idx <= pw_idx + 3'h1;
        end
    end
    assign pw_subcode_serial_out = pw_hold[pw_idx];

    // sequences for the sub q path
    sequence s_pass_block;
        block_done && crc_pass && !held;
    endsequence

    // a complete block whose check field disagrees, seen while not held
    sequence s_fail_block;
        block_done && !crc_pass && !held;
    endsequence

    property p_crc_load;
        @(posedge core_clk_in) disable iff (!resetn_in)
        s_pass_block |=> crc_flag && (word == $past(next_word));
    endproperty
    a_crc_load: assert property (p_crc_load) else $error("passing block not loaded");

    property p_no_load_held;
        @(posedge core_clk_in) disable iff (!resetn_in)
        held |=> $stable(word);
    endproperty
    a_no_load_held: assert property (p_no_load_held) else $error("word changed");

    property p_reverse;
        @(posedge core_clk_in) disable iff (!resetn_in)
        load_now |=> (word[0] == $past(s2p[72])) && (word[7] == $past(s2p[79]))
            && (word[8] == $past(s2p[64])) && (word[79] == $past(s2p[7]));
    endproperty
    a_reverse: assert property (p_reverse) else $error("byte bit order wrong");

    property p_held_low;
        @(posedge core_clk_in) disable iff (!resetn_in)
        !subq_shift_clock_s |=> (os_cnt == 16'h0000) && held;
    endproperty
    a_held_low: assert property (p_held_low) else $error("one-shot not held");

    property p_release;
        @(posedge core_clk_in) disable iff (!resetn_in)
        subq_shift_clock_s && (os_cnt == ONESHOT_CYCLES - 16'h0001) ##1 subq_shift_clock_s |-> !held;
    endproperty
    a_release: assert property (p_release) else $error("one-shot did not run out");

    property p_sq_feed;
        @(posedge core_clk_in) disable iff (!resetn_in)
        data_bit && !subq_sample_in.block_start |=> s2p[0] == $past(subq_sample_in.data);
    endproperty
    a_sq_feed: assert property (p_sq_feed) else $error("sub q bit not shifted in");

    property p_idle_flag;
        @(posedge core_clk_in) disable iff (!resetn_in)
        !held |=> subq_serial_out == $past(crc_flag);
    endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("idle output not flag");

    property p_advance;
        @(posedge core_clk_in) disable iff (!resetn_in)
        held && subq_shift_clock_rise && (rd_idx < csq_pkg::SUBQ_LOCK_INDEX) ##1 held
            |-> rd_idx == $past(rd_idx) + 7'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("read index did not advance");

    property p_lock;
        @(posedge core_clk_in) disable iff (!resetn_in)
        held && (rd_idx == csq_pkg::SUBQ_LOCK_INDEX)
            |=> subq_serial_out == $past(wide_pll_lock_flag_in);
    endproperty
    a_lock: assert property (p_lock) else $error("lock flag not shifted out");

    property p_pw_step;
        @(posedge pw_subcode_shift_clock_in) disable iff (!rstl_s)
        pw_idx != csq_pkg::PW_LAST_INDEX |=> pw_idx == $past(pw_idx) + 3'h1;
    endproperty
    a_pw_step: assert property (p_pw_step) else $error("p to w index did not step");

    property p_pw_wrap;
        @(posedge pw_subcode_shift_clock_in) disable iff (!rstl_s)
        pw_idx == csq_pkg::PW_LAST_INDEX |=> pw_idx == 3'h0;
    endproperty
    a_pw_wrap: assert property (p_pw_wrap) else $error("p to w index did not wrap");

    // a failing block must neither raise the flag nor touch the word
    property p_fail_no_load;
        @(posedge core_clk_in) disable iff (!resetn_in)
        s_fail_block |=> !crc_flag && $stable(word);
    endproperty
    a_fail_no_load: assert property (p_fail_no_load) else $error("bad block loaded");

    // a read start holds the one-shot and drops the flag, so a later rise is news
    property p_read_start;
        @(posedge core_clk_in) disable iff (!resetn_in)
        subq_shift_clock_fall |=> held && !crc_flag;
    endproperty
    a_read_start: assert property (p_read_start) else $error("read start kept flag");
endmodule
`default_nettype wire

// ### tb/csq_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module csq_host_model (
    // device outputs
    input wire logic subq_serial_in,
    input wire logic pw_serial_in,
    // host clocks
    output logic subq_clk_out,
    output logic pw_clk_out
);
    // sub q clock idles high; the link clock stands still outside frames
    initial begin
        subq_clk_out = 1'b1;
        pw_clk_out = 1'b0;
    end

    // eight link pulses; each bit is taken before the rise that advances it
    task automatic pw_read(output logic [7:0] sym);
        #3; // odd offset keeps the link out of phase with the core clock
        for (int j = 0; j < 8; j++) begin
            sym[j] = pw_serial_in;
            pw_clk_out = 1'b1;
            #6;
            pw_clk_out = 1'b0;
            #6;
        end
    endtask

    // bare link pulses that carry a reset release across to the link side
    task automatic pw_pulses(input int n);
        #3;
        repeat (n) begin
            pw_clk_out = 1'b1;
            #6;
            pw_clk_out = 1'b0;
            #6;
        end
    endtask

    // 80 pulses with 800 ns phases, then the lock bit; clock is left high
    task automatic sq_read(output logic [80:0] word);
        subq_clk_out = 1'b0;
        #800;
        word[0] = subq_serial_in;
        for (int k = 1; k <= 80; k++) begin
            subq_clk_out = 1'b1;
            #800;
            word[k] = subq_serial_in;
            if (k < 80) begin
                subq_clk_out = 1'b0;
                #800;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### tb/tb_cd_subcode_readout.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cd_subcode_readout;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    csq_pkg::csq_subq_sample_t subq_sample_in = '0;
    logic [7:0] pw_symbol_in = 8'h00;
    logic write_frame_clock_in = 1'b0;
    logic wide_pll_lock_flag_in = 1'b0;
    wire logic pw_clk;
    wire logic pw_out;
    wire logic sq_clk;
    wire logic sq_out;
    wire logic block_sync;
    wire logic crc_flag;
    int mismatches = 0;
    int num_checks = 0;
    logic [7:0] sym;
    logic [80:0] got;

    // short one-shot keeps the run brief; still longer than a clock phase
    csq_readout #(.ONESHOT_CYCLES(16'h00C8)) DUT (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .subq_sample_in(subq_sample_in),
        .pw_symbol_in(pw_symbol_in),
        .write_frame_clock_in(write_frame_clock_in),
        .wide_pll_lock_flag_in(wide_pll_lock_flag_in),
        .pw_subcode_shift_clock_in(pw_clk),
        .pw_subcode_serial_out(pw_out),
        .subq_shift_clock_in(sq_clk),
        .subq_serial_out(sq_out),
        .subcode_block_sync_out(block_sync),
        .subq_crc_ok_flag_out(crc_flag)
    );

    csq_host_model host (
        .subq_serial_in(sq_out),
        .pw_serial_in(pw_out),
        .subq_clk_out(sq_clk),
        .pw_clk_out(pw_clk)
    );

    // core clock, 100 MHz
    always #5 core_clk_in = ~core_clk_in;

    task automatic chk(input string name, input logic [80:0] exp, input logic [80:0] seen);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    // expected readout: bytes in order, bits of each byte reversed, then lock
    function automatic logic [80:0] exp_word(input logic [79:0] d, input logic lock);
        exp_word[80] = lock;
        for (int i = 0; i < 10; i++)
            for (int j = 0; j < 8; j++)
                exp_word[8 * i + j] = d[8 * (9 - i) + j];
    endfunction

    // one block: start pulse, 80 data bits msb first, 16 check bits
    task automatic send_block(input logic [79:0] d, input logic good);
        logic [15:0] crc;
        logic [95:0] blk;
        crc = 16'h0000;
        for (int i = 79; i >= 0; i--)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        blk = {d, good ? ~crc : crc};
        subq_sample_in = '{1'b1, 1'b0, 1'b0};
        cycles(1);
        chk("block sync", 81'(1), 81'(block_sync));
        for (int i = 95; i >= 0; i--) begin
            subq_sample_in = '{1'b0, 1'b1, blk[i]};
            cycles(1);
        end
        subq_sample_in = '0;
        cycles(3);
    endtask

    task automatic test_pw();
        logic [7:0] vals [2] = '{8'hA5, 8'h3C};
        for (int i = 0; i < 2; i++) begin
            write_frame_clock_in = 1'b1;
            pw_symbol_in = vals[i];
            cycles(2);
            write_frame_clock_in = 1'b0;
            cycles(2);
            host.pw_read(sym);
            chk("pw symbol", 81'(vals[i]), 81'(sym));
        end
    endtask

    task automatic test_read(input logic [79:0] d, input logic lock);
        send_block(d, 1'b1);
        chk("crc flag set", 81'(1), 81'(crc_flag));
        chk("new word rise", 81'(1), 81'(sq_out));
        wide_pll_lock_flag_in = lock;
        host.sq_read(got);
        chk("sub q word", exp_word(d, lock), got);
        cycles(300);
        chk("idle after read", 81'(0), 81'(sq_out));
    endtask

    // a passing block that lands during a read must not replace the word
    task automatic test_blocked(input logic [79:0] a, input logic [79:0] b);
        send_block(a, 1'b1);
        wide_pll_lock_flag_in = 1'b0;
        fork
            host.sq_read(got);
            begin
                cycles(200);
                send_block(b, 1'b1);
            end
        join
        chk("word kept", exp_word(a, 1'b0), got);
        cycles(300);
        chk("load refused", 81'(0), 81'(sq_out));
    endtask

    task automatic test_fail(input logic [79:0] d);
        send_block(d, 1'b1);
        chk("flag before", 81'(1), 81'(crc_flag));
        send_block(d, 1'b0);
        chk("flag on bad crc", 81'(0), 81'(crc_flag));
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the tests need about 0.4 ms
    initial begin
        #1000000;
        mismatches++;
        report_and_stop();
    end

    // link edges during reset carry the reset across to the link side too
    initial begin
        host.pw_read(sym);
        repeat (16) @(posedge core_clk_in);
        #1;
        resetn_in = 1'b1;
        // two spare link pulses let the link side leave reset with its index on p
        host.pw_pulses(2);
        cycles(2);
        test_pw();
        test_read(80'h0123456789ABCDEF0F1E, 1'b1);
        test_blocked(80'hF0E1D2C3B4A596870011, 80'h8001A55A3CC3FF00807F);
        test_read(80'h8001A55A3CC3FF00807F, 1'b0);
        test_fail(80'h13579BDF2468ACE05AA5);
        report_and_stop();
    end
endmodule
`default_nettype wire
